// ### hdl/count_prescaler.sv
`default_nettype none
module count_prescaler
    import timer_pkg::*;
(
    // clock and reset
    input wire logic i_clock,
    input wire logic i_resetn,
    // control
    input wire logic i_run,
    input wire logic [2:0] i_div_sel,
    // one-cycle count clock pulse
    output logic o_tick
);
    logic [PRESCALE_BITS-1:0] count;
    logic [PRESCALE_BITS-1:0] next_count;

    // low-bit mask for divide by 4 << sel
    function automatic logic [PRESCALE_BITS-1:0] div_mask(
        input logic [2:0] sel
    );
        logic [PRESCALE_BITS-1:0] m;
        m = 9'h003;
        div_mask = ((m + 9'h001) << sel) - 9'h001;
    endfunction

    // count while running, restart from zero when stopped
    always_comb begin
        next_count = i_run ? count + 9'h001 : 9'h000;
        o_tick = i_run &&
            ((count & div_mask(i_div_sel)) == div_mask(i_div_sel));
    end

    // register
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            count <= 9'h000;
        end else begin
            count <= next_count;
        end
    end
endmodule // count_prescaler
`default_nettype wire

// ### hdl/free_running_capture_compare_timer.sv
`default_nettype none
// Notes on behaviour
// - 16-bit counter, internal or external clock
// - wrap sets overflow flag and interrupt
// - first compare FFFF with clear: no overflow
// - clearing count enable zeroes without overflow
// - overflow stop halts until enable rewritten
// - enable rewritten while counting changes nothing
// - mode bit: 0 capture, 1 compare
// - capture latches count on valid trigger edge
// - valid trigger edge raises its interrupt
// - per-pin rising, falling or both edges
// - compare equality drives output and interrupt
// - zero matches only after wrap from FFFF
// - first match with clear restarts count
// - first match activates, second deactivates output
// - output level from enable and active level
// - equal compare values keep output inactive
// - clock select divides by 4 to 512
// - clock action 0 holds channel reset
// - external select counts event pin edges
// - overflow flag sticky until written zero
module free_running_capture_compare_timer
    import timer_pkg::*;
(
    // clock and reset
    input wire logic i_clock,
    input wire logic i_resetn,
    // ahb-lite slave
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic o_hreadyout,
    output logic o_hresp,
    output logic [31:0] o_hrdata,
    // external pins
    input wire logic i_trigger_pin_first,
    input wire logic i_trigger_pin_second,
    input wire logic i_event_clock_pin,
    output logic o_pulse_out,
    // interrupt requests
    output logic o_overflow_irq,
    output logic o_match_irq_first,
    output logic o_match_irq_second
);
    // bus state
    logic wr_pend;
    logic [7:0] wr_addr;
    logic clock_action_bit;
    logic next_wr_pend;
    logic [7:0] next_wr_addr;
    logic next_clock_action_bit;
    logic [31:0] next_hrdata;
    // channel state
    logic count_enable_bit;
    logic stopped;
    logic overflow_flag;
    logic [2:0] clock_div_sel;
    logic [7:0] channel_control_one;
    logic [7:0] edge_select_reg;
    logic [15:0] cap_cmp_first;
    logic [15:0] cap_cmp_second;
    logic [15:0] up_counter;
    logic pulse_state;
    logic clear_due;
    logic next_clear_due;
    logic next_count_enable_bit;
    logic next_stopped;
    logic next_overflow_flag;
    logic [2:0] next_clock_div_sel;
    logic [7:0] next_channel_control_one;
    logic [7:0] next_edge_select_reg;
    logic [15:0] next_cap_cmp_first;
    logic [15:0] next_cap_cmp_second;
    logic [15:0] next_up_counter;
    logic next_pulse_state;
    logic next_pulse_out;
    logic next_overflow_irq;
    logic next_match_irq_first;
    logic next_match_irq_second;
    // helpers
    logic chan_resetn;
    logic running;
    logic pre_tick;
    logic edge_first;
    logic edge_second;
    logic edge_event;
    logic tick;
    logic first_cmp;
    logic second_cmp;
    logic clear_now;
    logic match_first;
    logic match_second;
    logic [7:0] control_zero_view;
    logic wr_zero;

    // write target decode in the data phase
    function automatic logic hit(input logic pend, input logic [7:0] a,
                                 input logic [7:0] off);
        hit = pend && (a == off);
    endfunction

    // whole channel held in reset while clock action is off
    assign chan_resetn = i_resetn & clock_action_bit;
    assign running = count_enable_bit & ~stopped;
    assign first_cmp = channel_control_one[BIT_FIRST_MODE];
    assign second_cmp = channel_control_one[BIT_SECOND_MODE];
    assign wr_zero = hit(wr_pend, wr_addr, OFF_CONTROL_ZERO);

    // readable view of channel_control_zero
    assign control_zero_view = {overflow_flag, clock_div_sel, 2'h0,
                                count_enable_bit, clock_action_bit};

    // zero-wait slave, always okay
    assign o_hreadyout = 1'b1;
    assign o_hresp = 1'b0;

    count_prescaler u_prescaler (
        .i_clock(i_clock),
        .i_resetn(chan_resetn),
        .i_run(running),
        .i_div_sel(clock_div_sel),
        .o_tick(pre_tick)
    );

    trigger_edge u_edge_first (
        .i_clock(i_clock),
        .i_resetn(chan_resetn),
        .i_pin(i_trigger_pin_first),
        .i_edge_sel(edge_select_reg[POS_FIRST_EDGE +: 2]),
        .o_edge(edge_first)
    );

    trigger_edge u_edge_second (
        .i_clock(i_clock),
        .i_resetn(chan_resetn),
        .i_pin(i_trigger_pin_second),
        .i_edge_sel(edge_select_reg[POS_SECOND_EDGE +: 2]),
        .o_edge(edge_second)
    );

    trigger_edge u_edge_event (
        .i_clock(i_clock),
        .i_resetn(chan_resetn),
        .i_pin(i_event_clock_pin),
        .i_edge_sel(edge_select_reg[POS_EVENT_EDGE +: 2]),
        .o_edge(edge_event)
    );

    // bus phases, clock action bit and read data
    always_comb begin
        next_wr_pend = i_hsel && i_hready && i_htrans[HTRANS_ACTIVE]
                       && i_hwrite;
        next_wr_addr = i_haddr[7:0];
        next_clock_action_bit = clock_action_bit;
        if (wr_zero) begin
            next_clock_action_bit = i_hwdata[BIT_CLOCK_ACTION];
        end
        next_hrdata = o_hrdata;
        if (i_hsel && i_hready && i_htrans[HTRANS_ACTIVE] && !i_hwrite) begin
            case (i_haddr[7:0])
                OFF_CONTROL_ZERO: next_hrdata = {24'h0, control_zero_view};
                OFF_CONTROL_ONE: next_hrdata = {24'h0, channel_control_one};
                OFF_EDGE_SELECT: next_hrdata = {24'h0, edge_select_reg};
                OFF_CAP_CMP_FIRST: next_hrdata = {16'h0, cap_cmp_first};
                OFF_CAP_CMP_SECOND: next_hrdata = {16'h0, cap_cmp_second};
                OFF_UP_COUNTER: next_hrdata = {16'h0, up_counter};
                default: next_hrdata = 32'h0000_0000;
            endcase
        end
    end

    // bus registers
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
            clock_action_bit <= RST_CONTROL_ZERO[BIT_CLOCK_ACTION];
            o_hrdata <= 32'h0000_0000;
        end else begin
            wr_pend <= next_wr_pend;
            wr_addr <= next_wr_addr;
            clock_action_bit <= next_clock_action_bit;
            o_hrdata <= next_hrdata;
        end
    end

    // counting, capture, compare, output and interrupts
    always_comb begin
        next_count_enable_bit = count_enable_bit;
        next_stopped = stopped;
        next_overflow_flag = overflow_flag;
        next_clock_div_sel = clock_div_sel;
        next_channel_control_one = channel_control_one;
        next_edge_select_reg = edge_select_reg;
        next_cap_cmp_first = cap_cmp_first;
        next_cap_cmp_second = cap_cmp_second;
        next_up_counter = up_counter;
        next_pulse_state = pulse_state;
        next_clear_due = clear_due;
        next_overflow_irq = 1'b0;
        match_first = 1'b0;
        match_second = 1'b0;
        // count event source
        tick = running && (channel_control_one[BIT_EXT_CLOCK_SEL]
                           ? edge_event : pre_tick);
        // clear only after a counted match, so a start zero never clears
        clear_now = clear_due && first_cmp
                    && channel_control_one[BIT_CLEAR_ON_MATCH]
                    && (up_counter == cap_cmp_first);
        if (tick) begin
            if (clear_now) begin
                next_up_counter = RST_COUNT;
            end else begin
                next_up_counter = up_counter + 16'h0001;
                match_first = first_cmp
                    && (next_up_counter == cap_cmp_first);
                match_second = second_cmp
                    && (next_up_counter == cap_cmp_second);
                if (up_counter == COUNT_TOP) begin
                    next_overflow_irq = 1'b1;
                    next_stopped =
                        channel_control_one[BIT_OVERFLOW_STOP];
                end
            end
            next_clear_due = match_first;
        end
        // output flip-flop: second match wins when both hit
        if (match_first) begin
            next_pulse_state = 1'b1;
        end
        if (match_second) begin
            next_pulse_state = 1'b0;
        end
        // capture on valid trigger edges
        if (!first_cmp && edge_first) begin
            next_cap_cmp_first = up_counter;
        end
        if (!second_cmp && edge_second) begin
            next_cap_cmp_second = up_counter;
        end
        next_match_irq_first = first_cmp ? match_first : edge_first;
        next_match_irq_second = second_cmp ? match_second
                                           : edge_second;
        // software writes
        if (wr_zero) begin
            next_clock_div_sel = i_hwdata[BIT_DIV_SEL_HI:BIT_DIV_SEL_LO];
            next_overflow_flag = overflow_flag
                                 & i_hwdata[BIT_OVERFLOW_FLAG];
            if (!i_hwdata[BIT_COUNT_ENABLE]) begin
                next_count_enable_bit = 1'b0;
                next_stopped = 1'b0;
                next_clear_due = 1'b0;
                next_up_counter = RST_COUNT;
                next_overflow_irq = 1'b0;
            end else if (!running) begin
                next_count_enable_bit = 1'b1;
                next_stopped = 1'b0;
            end
        end
        if (hit(wr_pend, wr_addr, OFF_CONTROL_ONE)) begin
            next_channel_control_one = i_hwdata[7:0];
        end
        if (hit(wr_pend, wr_addr, OFF_EDGE_SELECT)) begin
            next_edge_select_reg = i_hwdata[7:0];
        end
        if (hit(wr_pend, wr_addr, OFF_CAP_CMP_FIRST)) begin
            next_cap_cmp_first = i_hwdata[15:0];
        end
        if (hit(wr_pend, wr_addr, OFF_CAP_CMP_SECOND)) begin
            next_cap_cmp_second = i_hwdata[15:0];
        end
        // overflow sets the sticky flag, set beats clear
        if (next_overflow_irq) begin
            next_overflow_flag = 1'b1;
        end
        // pin level from enable, active level and output state
        if (channel_control_one[BIT_OUTPUT_ENABLE]) begin
            next_pulse_out = channel_control_one[BIT_ACTIVE_LEVEL]
                             ? next_pulse_state : ~next_pulse_state;
        end else begin
            next_pulse_out = ~channel_control_one[BIT_ACTIVE_LEVEL];
        end
    end

    // channel registers, cleared by reset or clock action off
    always_ff @(posedge i_clock or negedge chan_resetn) begin
        if (!chan_resetn) begin
            count_enable_bit <= RST_CONTROL_ZERO[BIT_COUNT_ENABLE];
            stopped <= 1'b0;
            overflow_flag <= RST_CONTROL_ZERO[BIT_OVERFLOW_FLAG];
            clock_div_sel <= RST_CONTROL_ZERO[BIT_DIV_SEL_HI:BIT_DIV_SEL_LO];
            channel_control_one <= RST_CONTROL_ONE;
            edge_select_reg <= RST_EDGE_SELECT;
            cap_cmp_first <= RST_COUNT;
            cap_cmp_second <= RST_COUNT;
            up_counter <= RST_COUNT;
            pulse_state <= 1'b0;
            clear_due <= 1'b0;
            o_pulse_out <= 1'b0;
            o_overflow_irq <= 1'b0;
            o_match_irq_first <= 1'b0;
            o_match_irq_second <= 1'b0;
        end else begin
            count_enable_bit <= next_count_enable_bit;
            stopped <= next_stopped;
            overflow_flag <= next_overflow_flag;
            clock_div_sel <= next_clock_div_sel;
            channel_control_one <= next_channel_control_one;
            edge_select_reg <= next_edge_select_reg;
            cap_cmp_first <= next_cap_cmp_first;
            cap_cmp_second <= next_cap_cmp_second;
            up_counter <= next_up_counter;
            pulse_state <= next_pulse_state;
            clear_due <= next_clear_due;
            o_pulse_out <= next_pulse_out;
            o_overflow_irq <= next_overflow_irq;
            o_match_irq_first <= next_match_irq_first;
            o_match_irq_second <= next_match_irq_second;
        end
    end
endmodule // free_running_capture_compare_timer
`default_nettype wire

// ### hdl/timer_pkg.sv
`default_nettype none
package timer_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_CONTROL_ZERO = 8'h00;
    localparam logic [7:0] OFF_CONTROL_ONE = 8'h04;
    localparam logic [7:0] OFF_EDGE_SELECT = 8'h08;
    localparam logic [7:0] OFF_CAP_CMP_FIRST = 8'h0c;
    localparam logic [7:0] OFF_CAP_CMP_SECOND = 8'h10;
    localparam logic [7:0] OFF_UP_COUNTER = 8'h14;
    // values after reset
    localparam logic [7:0] RST_CONTROL_ZERO = 8'h00;
    localparam logic [7:0] RST_CONTROL_ONE = 8'h20;
    localparam logic [7:0] RST_EDGE_SELECT = 8'h00;
    localparam logic [15:0] RST_COUNT = 16'h0000;
    localparam logic [15:0] COUNT_TOP = 16'hffff;
    // channel_control_zero fields
    localparam int BIT_OVERFLOW_FLAG = 7;
    localparam int BIT_DIV_SEL_HI = 6;
    localparam int BIT_DIV_SEL_LO = 4;
    localparam int BIT_COUNT_ENABLE = 1;
    localparam int BIT_CLOCK_ACTION = 0;
    // channel_control_one fields
    localparam int BIT_OVERFLOW_STOP = 7;
    localparam int BIT_OUTPUT_ENABLE = 6;
    localparam int BIT_ACTIVE_LEVEL = 5;
    localparam int BIT_EXT_CLOCK_SEL = 4;
    localparam int BIT_CLEAR_ON_MATCH = 3;
    localparam int BIT_SECOND_MODE = 1;
    localparam int BIT_FIRST_MODE = 0;
    // edge_select_reg fields, two bits each
    localparam int POS_FIRST_EDGE = 0;
    localparam int POS_SECOND_EDGE = 2;
    localparam int POS_EVENT_EDGE = 6;
    // edge codes
    localparam logic [1:0] EDGE_FALL = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_BOTH = 2'h3;
    // prescaler: divide by 4 << select
    localparam int PRESCALE_BITS = 9;
    // ahb transfer type bit marking nonseq or seq
    localparam int HTRANS_ACTIVE = 1;
endpackage : timer_pkg
`default_nettype wire

// ### hdl/trigger_edge.sv
`default_nettype none
module trigger_edge
    import timer_pkg::*;
(
    // clock and reset
    input wire logic i_clock,
    input wire logic i_resetn,
    // pin and edge choice
    input wire logic i_pin,
    input wire logic [1:0] i_edge_sel,
    // detected valid edge
    output logic o_edge
);
    logic sync_first;
    logic sync_second;
    logic prev;
    logic rise;
    logic fall;

    // two-stage synchroniser plus history flop
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            sync_first <= 1'b0;
            sync_second <= 1'b0;
            prev <= 1'b0;
        end else begin
            sync_first <= i_pin;
            sync_second <= sync_first;
            prev <= sync_second;
        end
    end

    // valid edge per select code
    always_comb begin
        rise = sync_second & ~prev;
        fall = ~sync_second & prev;
        case (i_edge_sel)
            EDGE_FALL: o_edge = fall;
            EDGE_RISE: o_edge = rise;
            EDGE_BOTH: o_edge = rise | fall;
            default: o_edge = 1'b0;
        endcase
    end
endmodule // trigger_edge
`default_nettype wire

// ### sim/free_running_capture_compare_timer_assertions.sv
`default_nettype none
module timer_checker (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_resetn,
    // bus
    input wire logic i_hsel,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic i_hready,
    input wire logic o_hreadyout,
    input wire logic o_hresp,
    input wire logic [31:0] o_hrdata,
    // pins and requests
    input wire logic o_pulse_out,
    input wire logic o_overflow_irq,
    input wire logic o_match_irq_first,
    input wire logic o_match_irq_second
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_resetn);
    // first edge after reset release
    sequence out_of_reset;
        $rose(i_resetn);
    endsequence
    // no read taken in this address phase
    sequence no_read;
        !(i_hsel && i_hready && i_htrans[1] && !i_hwrite);
    endsequence
    hready_one_a: assert property (o_hreadyout)
        else $error("hreadyout low");
    okay_resp_a: assert property (!o_hresp)
        else $error("response not okay");
    rdata_hold_a: assert property (no_read |=> $stable(o_hrdata))
        else $error("read data moved without a read");
    ovf_pulse_a: assert property (o_overflow_irq |=> !o_overflow_irq)
        else $error("overflow request too long");
    first_pulse_a: assert property (
        o_match_irq_first |=> !o_match_irq_first)
        else $error("first request too long");
    second_pulse_a: assert property (
        o_match_irq_second |=> !o_match_irq_second)
        else $error("second request too long");
    reset_idle_a: assert property (
        out_of_reset |-> !o_pulse_out && !o_overflow_irq)
        else $error("outputs active after reset");
    irq_quiet_a: assert property (
        out_of_reset |-> !o_match_irq_first [*3])
        else $error("match request while channel held");
endmodule // timer_checker
bind free_running_capture_compare_timer timer_checker i_checker (
    .i_clock, .i_resetn, .i_hsel, .i_htrans, .i_hwrite, .i_hready,
    .o_hreadyout, .o_hresp, .o_hrdata, .o_pulse_out, .o_overflow_irq,
    .o_match_irq_first, .o_match_irq_second);
`default_nettype wire

// ### sim/free_running_capture_compare_timer_tb_top.sv
`default_nettype none
module free_running_capture_compare_timer_tb_top import timer_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, rstn = 0, hsel = 0, hwrite = 0, run = 0;
    logic [31:0] haddr = 0, hwdata = 0, v, w;
    logic [1:0] htrans = 0;
    logic [2:0] hsize = 3'h2;
    wire hready, resp, pulse, ovf, m1, m2, t1, t2, ev;
    wire [31:0] hrdata;
    int errors = 0, cmp_count = 0, n_ovf = 0, n_m1 = 0, n_m2 = 0, k;
    free_running_capture_compare_timer i_dut (.i_clock(clk),
        .i_resetn(rstn), .i_hsel(hsel), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
        .i_hwdata(hwdata), .i_hready(hready), .o_hreadyout(hready),
        .o_hresp(resp), .o_hrdata(hrdata), .i_trigger_pin_first(t1),
        .i_trigger_pin_second(t2), .i_event_clock_pin(ev),
        .o_pulse_out(pulse), .o_overflow_irq(ovf),
        .o_match_irq_first(m1), .o_match_irq_second(m2));
    timer_pin_partner i_partner (.i_clock(clk), .i_run(run),
        .o_trig_first(t1), .o_trig_second(t2), .o_event_pin(ev));
    // system clock, 100 ns period
    initial forever #50 clk = ~clk;
    // count request pulses where they are settled
    always @(negedge clk) begin
        n_ovf += int'(ovf === 1'b1);
        n_m1 += int'(m1 === 1'b1);
        n_m2 += int'(m2 === 1'b1);
    end
    // one single ahb transfer, entered just after a rising edge
    task automatic xfer(input logic wr, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        q = hrdata;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, v);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0, w);
        chk(w, exp);
    endtask
    // bounded wait until a pulse counter moves
    task automatic wait_chg(ref int n);
        int old;
        old = n;
        for (int i = 0; i < 300 && n == old; i++) @(posedge clk);
    endtask
    task automatic wrap_up;
        $display("errors=%0d compares=%0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // watchdog
    initial begin
        repeat (90000) @(posedge clk);
        errors++;
        wrap_up;
    end
    // main sequence
    initial begin
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rdc(OFF_CONTROL_ZERO, 32'(RST_CONTROL_ZERO));
        rdc(OFF_CONTROL_ONE, 32'(RST_CONTROL_ONE));
        rdc(OFF_EDGE_SELECT, 32'(RST_EDGE_SELECT));
        rdc(8'h1c, 32'h0);
        wr(OFF_CONTROL_ONE, 32'h08);
        rdc(OFF_CONTROL_ONE, 32'h20);
        wr(OFF_CONTROL_ZERO, 32'h01);
        wr(OFF_UP_COUNTER, 32'h1234);
        rdc(OFF_UP_COUNTER, 32'(RST_COUNT));
        chk(32'(pulse), 32'h0);
        wr(OFF_CONTROL_ONE, 32'h00);
        repeat (2) @(posedge clk);
        chk(32'(pulse), 32'h1);
        // every edge code on both trigger pins
        for (int c = 0; c < 4; c++) begin
            wr(OFF_EDGE_SELECT, 32'(c * 5));
            k = n_m1;
            v = 32'(n_m2);
            w = (c == 3) ? 32'h2 : (c == 2) ? 32'h0 : 32'h1;
            i_partner.pulse(1'b1, 1'b1);
            chk(32'(n_m1 - k), w);
            chk(32'(n_m2) - v, w);
        end
        wr(OFF_EDGE_SELECT, 32'h05);
        wr(OFF_CONTROL_ZERO, 32'h03);
        repeat (40) @(posedge clk);
        i_partner.pulse(1'b1, 1'b0);
        xfer(1'b0, OFF_CAP_CMP_FIRST, 32'h0, v);
        chk(32'(v > 0 && v < 32'h40), 32'h1);
        repeat (20) @(posedge clk);
        rdc(OFF_CAP_CMP_FIRST, v);
        xfer(1'b0, OFF_UP_COUNTER, 32'h0, v);
        wr(OFF_CONTROL_ZERO, 32'h03);
        xfer(1'b0, OFF_UP_COUNTER, 32'h0, w);
        chk(32'(w > v), 32'h1);
        wr(OFF_CONTROL_ZERO, 32'h01);
        rdc(OFF_UP_COUNTER, 32'h0);
        chk(32'(n_ovf), 32'h0);
        // interval and pulse output, for both active levels
        for (int al = 1; al >= 0; al--) begin
            wr(OFF_CONTROL_ONE, 32'h4b | 32'(al << 5));
            wr(OFF_CAP_CMP_FIRST, 32'h3);
            wr(OFF_CAP_CMP_SECOND, 32'h2);
            wr(OFF_CONTROL_ZERO, 32'h03);
            wait_chg(n_m1);
            repeat (4) @(posedge clk);
            chk(32'(pulse), 32'(al));
            wait_chg(n_m2);
            repeat (2) @(posedge clk);
            chk(32'(pulse), 32'(1 - al));
            wait_chg(n_m1);
            k = n_m1;
            repeat (56) @(posedge clk);
            chk(32'(n_m1 - k), 32'h3);
            wr(OFF_CONTROL_ZERO, 32'h01);
        end
        wr(OFF_CONTROL_ONE, 32'h6b);
        wr(OFF_CAP_CMP_FIRST, 32'h2);
        wr(OFF_CAP_CMP_SECOND, 32'h2);
        wr(OFF_CONTROL_ZERO, 32'h03);
        repeat (60) @(posedge clk);
        chk(32'(pulse), 32'h0);
        wr(OFF_CONTROL_ZERO, 32'h01);
        // event counting through a wrap, with stop after overflow
        wr(OFF_CONTROL_ONE, 32'h91);
        wr(OFF_EDGE_SELECT, 32'hc0);
        wr(OFF_CAP_CMP_FIRST, 32'h0);
        k = n_m1;
        wr(OFF_CONTROL_ZERO, 32'h03);
        run <= 1'b1;
        for (int i = 0; i < 70000 && n_ovf == 0; i++) @(posedge clk);
        repeat (8) @(posedge clk);
        chk(32'(n_ovf), 32'h1);
        chk(32'(n_m1 - k), 32'h1);
        rdc(OFF_UP_COUNTER, 32'h0);
        rdc(OFF_CONTROL_ZERO, 32'h83);
        run <= 1'b0;
        // let edges still in the pin synchroniser drain before restart
        repeat (4) @(posedge clk);
        wr(OFF_CONTROL_ZERO, 32'h03);
        rdc(OFF_CONTROL_ZERO, 32'h03);
        run <= 1'b1;
        repeat (20) @(posedge clk);
        run <= 1'b0;
        repeat (6) @(posedge clk);
        xfer(1'b0, OFF_UP_COUNTER, 32'h0, v);
        chk(32'(v > 13 && v < 21), 32'h1);
        wrap_up;
    end
endmodule // free_running_capture_compare_timer_tb_top
`default_nettype wire

// ### sim/timer_pin_partner.sv
`default_nettype none
module timer_pin_partner (
    // clock and pacing
    input wire logic i_clock,
    input wire logic i_run,
    // pins toward the timer
    output var logic o_trig_first,
    output var logic o_trig_second,
    output var logic o_event_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    // pins idle low from time zero
    initial begin
        o_trig_first = 1'b0;
        o_trig_second = 1'b0;
        o_event_pin = 1'b0;
    end
    // event clock toggles every cycle while running, standing still else
    always @(posedge i_clock) begin
        if (i_run) o_event_pin <= ~o_event_pin;
    end
    // one wide pulse on the chosen trigger pins, slow enough to sync
    task automatic pulse(input logic a, input logic b);
        o_trig_first <= a;
        o_trig_second <= b;
        repeat (6) @(posedge i_clock);
        o_trig_first <= 1'b0;
        o_trig_second <= 1'b0;
        repeat (6) @(posedge i_clock);
    endtask
endmodule // timer_pin_partner
`default_nettype wire
